/* bench/host_grant_model.sv */
/* host-side arbiter model: grants pair zero and pairs one to four, one
   at a time, and acknowledges hold. assumes the block's pci clock. */
`timescale 1ns/100ps
`default_nettype none
module host_grant_model #(
    parameter int TENURE = 4
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_slow,
    input  wire logic [4:0] i_request_n,
    output logic      [4:0] o_grant_n,
    input  wire logic       i_hold_n,
    output logic            o_hold_ack_n
);
    // ----------------------------------------
    // grant engine
    // ----------------------------------------
    int         cnt;
    logic [4:0] want;
    assign want = ~i_request_n;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_grant_n    <= 5'h1f;
            o_hold_ack_n <= 1'b1;
            cnt          <= 0;
        end else begin
            o_hold_ack_n <= i_hold_n;
            if (o_grant_n != 5'h1f) begin
                // tenure capped by TENURE, or ended early when the pair's request drops, so a shared pair can rotate
                cnt <= cnt + 1;
                if (cnt >= TENURE || (~o_grant_n & want) == 5'h0) begin
                    o_grant_n <= 5'h1f;
                    cnt       <= 0;
                end
            end else if (want == 5'h0) begin
                cnt <= 0;
            end else if (cnt < (i_slow ? 4 : 2)) begin
                cnt <= cnt + 1;
            end else begin
                cnt       <= 0;
                o_grant_n <= ~(want & (~want + 5'h1));
            end
        end
    end
endmodule // host_grant_model
`default_nettype wire

/* bench/pci_arb_fanout_bench.sv */
/* bench for pci_arb_fanout: bench drives masters, hold and ad; host
   grants come from host_grant_model. assumes a 25 mhz clock. */
`timescale 1ns/100ps
`default_nettype none
module pci_arb_fanout_bench;
    import arb_fanout_pkg::*;
    // ----------------------------------------
    // stimulus and wiring
    // ----------------------------------------
    logic        clk = 1'b0, rst_b = 1'b0, slow = 1'b0, hold_n = 1'b1;
    logic        scsi_n = 1'b1, nic_n = 1'b1, phase = 1'b0, clk_en = 1'b1;
    logic [3:0]  slot_n = 4'hf;
    logic [31:0] ad = 32'h0;
    wire logic [4:0] hr, hg;
    wire logic [2:0] gup;
    wire logic       ga, gb, gnic, hfwd, hack, halt;
    wire logic [5:0] gv = {gnic, gup, gb, ga};
    cfg_sel_t    sel;
    int          errors = 0, n_compared = 0;
    always #20 clk = ~clk;
    pci_arb_fanout i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_clk_en(clk_en),
        .i_slot_request_n(slot_n), .i_scsi_request_n(scsi_n),
        .i_nic_request_n(nic_n), .o_pair_zero_request_n(hr[0]),
        .i_pair_zero_grant_n(hg[0]), .o_pair_request_n(hr[4:1]),
        .i_pair_grant_n(hg[4:1]), .o_ext0_sub_a_grant_n(ga),
        .o_ext0_sub_b_grant_n(gb), .o_slot_upper_grant_n(gup),
        .o_nic_grant_n(gnic), .i_southbridge_hold_request_n(hold_n),
        .o_southbridge_hold_fwd_n(hfwd), .i_southbridge_hold_ack_n(hack),
        .o_southbridge_hold_ack_alt_n(halt), .i_ad(ad),
        .i_cfg_phase(phase), .o_cfg_sel(sel));
    host_grant_model i_host (.i_clk_sys(clk), .i_rst_b(rst_b), .i_slow(slow),
        .i_request_n(hr), .o_grant_n(hg), .i_hold_n(hfwd),
        .o_hold_ack_n(hack));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // bounded wait for some grant (1) or for all grants gone (0)
    task automatic wait_gv(bit any);
        int k;
        for (k = 0; k < 30 && (any ? gv === 6'h3f : gv !== 6'h3f); k++) begin
            cyc(1);
        end
        if (k == 30) begin
            errors++;
            close_out();
        end
    endtask
    function automatic logic [7:0] exp_sel(int b);
        case (b)
            22: return 8'h80;
            23: return 8'h40;
            24: return 8'h20;
            25: return 8'h10;
            26: return 8'h08;
            27: return 8'h04;
            29: return 8'h02;
            31: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_round_robin();
        @(posedge clk);
        slot_n[0] <= 1'b0;
        scsi_n    <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wait_gv(1);
            chk("sub grant", k[0] ? 6'h3d : 6'h3e, gv);
            chk("upstream request", 5'h1e, hr);
            wait_gv(0);
        end
        @(posedge clk);
        slot_n[0] <= 1'b1;
        scsi_n    <= 1'b1;
        cyc(4);
        chk("released", 5'h1f, hr);
        $display("done round robin");
    endtask
    task automatic t_pairs();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            slow <= i[0];
            if (i < 3) slot_n[i+1] <= 1'b0;
            else nic_n <= 1'b0;
            wait_gv(1);
            chk("pair grant", 6'h3f ^ (6'h4 << i), gv);
            chk("pair request", 5'h1f ^ (5'h2 << i), hr);
            @(posedge clk);
            slot_n <= 4'hf;
            nic_n  <= 1'b1;
            wait_gv(0);
        end
        $display("done pairs");
    endtask
    task automatic t_hold();
        // enable low must freeze the pass-through
        @(posedge clk);
        clk_en <= 1'b0;
        hold_n <= 1'b0;
        cyc(3);
        chk("frozen hold", 2'b11, {hfwd, halt});
        @(posedge clk);
        clk_en <= 1'b1;
        cyc(3);
        chk("hold path", 2'b00, {hfwd, halt});
        chk("no pair used", 5'h1f, hr);
        @(posedge clk);
        hold_n <= 1'b1;
        cyc(3);
        chk("hold idle", 2'b11, {hfwd, halt});
        $display("done hold");
    endtask
    task automatic t_cfg();
        for (int b = 11; b < 32; b++) begin
            @(posedge clk);
            ad    <= 32'h1 << b;
            phase <= 1'b1;
            cyc(1);
            chk("config select", exp_sel(b), sel);
        end
        @(posedge clk);
        phase <= 1'b0;
        cyc(1);
        chk("select idle", 8'h00, sel);
        $display("done config select");
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cyc(2);
        chk("reset grants", 6'h3f, gv);
        chk("reset outputs", 12'hfe0, {hr, hfwd, halt, sel[7:3]});
        @(posedge clk);
        rst_b <= 1'b1;
        cyc(2);
        chk("idle requests", 5'h1f, hr);
        $display("done reset");
        t_round_robin();
        t_pairs();
        t_hold();
        t_cfg();
        close_out();
    end
endmodule // pci_arb_fanout_bench
`default_nettype wire

/* hdl/pci_arb_fanout.sv */
/*
 * pci arbitration fan-out: pair-zero round-robin extension, upstream
 * pair routing, hold handshake pass and
 * configuration select decode.
 * assumes all inputs synchronous to the pci clock; undriven slot
 * requests arrive pulled high (inactive).
 */
`timescale 1ns/100ps
`default_nettype none
module pci_arb_fanout
    import arb_fanout_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic             i_clk_en,
    // slot and onboard master requests (active low)
    input  wire logic [3:0]       i_slot_request_n,
    input  wire logic             i_scsi_request_n,
    input  wire logic             i_nic_request_n,
    // host bridge pair zero
    output logic                  o_pair_zero_request_n,
    input  wire logic             i_pair_zero_grant_n,
    // host bridge pairs one to four
    output logic [3:0]            o_pair_request_n,
    input  wire logic [3:0]       i_pair_grant_n,
    // grants back to masters
    output logic                  o_ext0_sub_a_grant_n,
    output logic                  o_ext0_sub_b_grant_n,
    output logic [2:0]            o_slot_upper_grant_n,
    output logic                  o_nic_grant_n,
    // south bridge hold handshake
    input  wire logic             i_southbridge_hold_request_n,
    output logic                  o_southbridge_hold_fwd_n,
    input  wire logic             i_southbridge_hold_ack_n,
    output logic                  o_southbridge_hold_ack_alt_n,
    // configuration select decode
    input  wire logic [AD_W-1:0]  i_ad,
    input  wire logic             i_cfg_phase,
    output cfg_sel_t              o_cfg_sel
);
    // ------------------------------------------------------------
    // pair zero extension state
    // ------------------------------------------------------------
    logic ext0_sub_a_request_n;
    logic ext0_sub_b_request_n;
    sub_t sel;
    sub_t next_sel;
    logic req0_n;
    logic next_req0_n;
    logic gnt_a_n;
    logic next_gnt_a_n;
    logic gnt_b_n;
    logic next_gnt_b_n;
    logic gnt_a;
    logic gnt_b;

    // undriven slot requests pull high, so high simply means idle
    assign ext0_sub_a_request_n = i_slot_request_n[0];
    assign ext0_sub_b_request_n = i_scsi_request_n;
    // flops keep the pin level so the grant pins leave a flop directly
    assign gnt_a = !gnt_a_n;
    assign gnt_b = !gnt_b_n;

    always_comb begin
        next_sel   = sel;
        next_req0_n  = ext0_sub_a_request_n && ext0_sub_b_request_n;
        next_gnt_a_n = i_pair_zero_grant_n || sel != SUB_A;
        next_gnt_b_n = i_pair_zero_grant_n || sel != SUB_B;
        // reselect only with no grant outstanding, avoiding a stolen bus
        if (i_pair_zero_grant_n && !gnt_a && !gnt_b) begin
            case (sel)
                SUB_A: begin
                    if (ext0_sub_a_request_n && !ext0_sub_b_request_n)
                        next_sel = SUB_B;
                end
                SUB_B: begin
                    if (ext0_sub_b_request_n && !ext0_sub_a_request_n)
                        next_sel = SUB_A;
                end
                default: next_sel = SUB_A;
            endcase
        end
        // on grant release with the other sub-channel requesting, hand over in turn
        if ((gnt_a || gnt_b) && i_pair_zero_grant_n) begin
            if (gnt_a && !ext0_sub_b_request_n)
                next_sel = SUB_B;
            else if (gnt_b && !ext0_sub_a_request_n)
                next_sel = SUB_A;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel     <= SUB_A;
            req0_n  <= 1'b1;
            gnt_a_n <= 1'b1;
            gnt_b_n <= 1'b1;
        end else if (i_clk_en) begin
            sel     <= next_sel;
            req0_n  <= next_req0_n;
            gnt_a_n <= next_gnt_a_n;
            gnt_b_n <= next_gnt_b_n;
        end
    end

    // ------------------------------------------------------------
    // pairs one to four and hold handshake
    // ------------------------------------------------------------
    logic [3:0] pair_req_n;
    logic [3:0] next_pair_req_n;
    logic [3:0] pair_gnt_n;
    logic [3:0] next_pair_gnt_n;
    logic       hold_n;
    logic       next_hold_n;
    logic       hold_ack_n;
    logic       next_hold_ack_n;

    always_comb begin
        // one register stage each way; host bridge sees host requests
        // internally so no pair exists for it; video has none either
        next_pair_req_n = {i_nic_request_n, i_slot_request_n[3:1]};
        next_pair_gnt_n = i_pair_grant_n;
        next_hold_n     = i_southbridge_hold_request_n;
        next_hold_ack_n = i_southbridge_hold_ack_n;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pair_req_n <= 4'hf;
            pair_gnt_n <= 4'hf;
            hold_n     <= 1'b1;
            hold_ack_n <= 1'b1;
        end else if (i_clk_en) begin
            pair_req_n <= next_pair_req_n;
            pair_gnt_n <= next_pair_gnt_n;
            hold_n     <= next_hold_n;
            hold_ack_n <= next_hold_ack_n;
        end
    end

    // ------------------------------------------------------------
    // configuration select decode
    // ------------------------------------------------------------
    cfg_sel_t cfg_sel;
    cfg_sel_t next_cfg_sel;

    always_comb begin
        next_cfg_sel = '0;
        if (i_cfg_phase) begin
            next_cfg_sel.slot1 = i_ad[SEL_SLOT1];
            next_cfg_sel.slot2 = i_ad[SEL_SLOT2];
            next_cfg_sel.scsi  = i_ad[SEL_SCSI];
            next_cfg_sel.slot3 = i_ad[SEL_SLOT3];
            next_cfg_sel.nic   = i_ad[SEL_NIC];
            next_cfg_sel.slot4 = i_ad[SEL_SLOT4];
            next_cfg_sel.south = i_ad[SEL_SOUTH];
            next_cfg_sel.video = i_ad[SEL_VIDEO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b)
            cfg_sel <= '0;
        else if (i_clk_en)
            cfg_sel <= next_cfg_sel;
    end

    assign o_pair_zero_request_n        = req0_n;
    assign o_ext0_sub_a_grant_n         = gnt_a_n;
    assign o_ext0_sub_b_grant_n         = gnt_b_n;
    assign o_pair_request_n             = pair_req_n;
    assign o_slot_upper_grant_n         = pair_gnt_n[2:0];
    assign o_nic_grant_n                = pair_gnt_n[3];
    assign o_southbridge_hold_fwd_n     = hold_n;
    assign o_southbridge_hold_ack_alt_n = hold_ack_n;
    assign o_cfg_sel                    = cfg_sel;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_one_sub_grant;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !(gnt_a && gnt_b);
    endproperty
    a_one_sub_grant: assert property (p_one_sub_grant)
        else $error("both sub grants active");

    property p_upstream_req;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_clk_en && (!i_slot_request_n[0] || !i_scsi_request_n))
        |=> !o_pair_zero_request_n;
    endproperty
    a_upstream_req: assert property (p_upstream_req)
        else $error("pair zero request not raised");

    property p_sel_stable;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (gnt_a || gnt_b) && !i_pair_zero_grant_n |=> $stable(sel);
    endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("selection moved under grant");

    property p_round_robin;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_clk_en && gnt_a && i_pair_zero_grant_n && !i_scsi_request_n)
        |=> sel == SUB_B;
    endproperty
    a_round_robin: assert property (p_round_robin)
        else $error("no hand-over to sub b");

    property p_grant_route;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_clk_en && !i_pair_zero_grant_n && sel == SUB_B)
        |=> !o_ext0_sub_b_grant_n && o_ext0_sub_a_grant_n;
    endproperty
    a_grant_route: assert property (p_grant_route)
        else $error("grant misrouted");

    property p_idle_slot;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_clk_en && &i_slot_request_n[3:1]) |=> &o_pair_request_n[2:0];
    endproperty
    a_idle_slot: assert property (p_idle_slot)
        else $error("idle slot requested");

    property p_hold_pass;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_clk_en && !i_southbridge_hold_request_n)
        |=> !o_southbridge_hold_fwd_n;
    endproperty
    a_hold_pass: assert property (p_hold_pass)
        else $error("hold request lost");

    property p_cfg_video;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_clk_en && i_cfg_phase && i_ad[SEL_VIDEO]) |=> o_cfg_sel.video;
    endproperty
    a_cfg_video: assert property (p_cfg_video)
        else $error("video select missed");

    c_both_req: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !i_slot_request_n[0] && !i_scsi_request_n);
    c_gnt_b: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        gnt_b);
    c_hold: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !hold_n ##1 !hold_ack_n);
endmodule // pci_arb_fanout
`default_nettype wire

/* pkg/arb_fanout_pkg.sv */
/*
 * package for the pci arbitration fan-out block: master counts,
 * configuration select mapping, widths.
 * assumes a single pci clock domain and active-low pci signalling.
 */
`default_nettype none
package arb_fanout_pkg;
    // ------------------------------------------------------------
    // master population
    // ------------------------------------------------------------
    localparam int unsigned NUM_MASTERS   = 8;
    localparam int unsigned NUM_EXT_PAIRS = 5;
    localparam int unsigned NUM_SLOTS     = 4;
    // ------------------------------------------------------------
    // configuration select bits on the address/data bus
    // ------------------------------------------------------------
    localparam int unsigned AD_W          = 32;
    localparam int unsigned CFG_SEL_LOW   = 11;
    localparam int unsigned SEL_SLOT1     = 22;
    localparam int unsigned SEL_SLOT2     = 23;
    localparam int unsigned SEL_SCSI      = 24;
    localparam int unsigned SEL_SLOT3     = 25;
    localparam int unsigned SEL_NIC       = 26;
    localparam int unsigned SEL_SLOT4     = 27;
    localparam int unsigned SEL_SOUTH     = 29;
    localparam int unsigned SEL_VIDEO     = 31;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic slot1;
        logic slot2;
        logic scsi;
        logic slot3;
        logic nic;
        logic slot4;
        logic south;
        logic video;
    } cfg_sel_t;
    // sub-channel identity of pair zero
    typedef enum logic {SUB_A, SUB_B} sub_t;
endpackage
`default_nettype wire
